// ---- bench/mssp_periph.sv ----
`timescale 1ns/1ps
`default_nettype none
// Far-side serial peripheral: answers with a preset byte, MSB first,
// and collects what the port shifts out
module mssp_periph (
    input  wire logic       sck,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       din,
    input  wire logic       load,
    input  wire logic [7:0] reply,
    output logic            dout,
    output logic      [7:0] got
);
    logic [3:0] k = 4'h8;
    logic       first = 1'b0;

    always @(posedge load) begin
        k = 4'h0;
        first = 1'b1;
    end

    // Sample on the leading edge for phase 0, trailing for phase 1
    always @(sck) begin
        if ((sck != cpol) ^ cpha) begin
            got = {got[6:0], din};
        end else if (!(cpha && first) && k < 4'h8) begin
            k = k + 4'h1;
        end
        first = 1'b0;
    end

    // Outside a frame the line is not held: show the inverse, never a stale bit
    assign dout = (k < 4'h8) ? reply[3'h7 - k[2:0]] : ~reply[0];
endmodule // mssp_periph
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mssp_pkg::*;
;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        ext_pin = 0, load = 0, cpol = 0, cpha = 0, sck_q = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  reply = 8'h0;
    logic [31:0] cyc = 0, edges = 0, t_first = 0, t_last = 0;
    logic [31:0] error_cnt = 0, comparisons = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, so_o, so_oe, sck_o, sck_oe, xirq, irq, miso;
    logic [7:0]  got;
    wire         sdo_w = so_oe ? so_o : 1'b1;
    wire         sck_w = sck_oe ? sck_o : 1'b1;

    mssp_top DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_out_line_o(so_o), .serial_out_line_oe(so_oe), .serial_in_line_i(miso),
        .sck_o(sck_o), .sck_oe(sck_oe), .sck_i(sck_w),
        .external_irq_channel_two_pin(ext_pin), .external_irq_channel_two(xirq), .irq(irq));
    mssp_periph peer (.sck(sck_w), .cpol(cpol), .cpha(cpha), .din(sdo_w), .load(load),
        .reply(reply), .dout(miso), .got(got));

    always #2.5 clk = ~clk;

    // Watch the shift clock on the falling edge, where the design's outputs have settled
    always @(negedge clk) begin
        cyc <= cyc + 32'h1;
        sck_q <= sck_o;
        if (!rst && sck_o !== sck_q) begin
            if (edges == 32'h0) t_first = cyc;
            t_last = cyc;
            edges = edges + 32'h1;
        end
        if (cyc == 32'h4E20) begin
            error_cnt = error_cnt + 32'h1;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons = comparisons + 32'h1;
        if (g !== e) begin
            error_cnt = error_cnt + 32'h1;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Holds the request until pready is sampled high; one idle edge after release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask

    task automatic xfer(input logic [1:0] m, input logic [1:0] rt, input logic [7:0] tx,
                        input logic [7:0] rp);
        logic [31:0] d, half[4];
        int          n;
        half = '{32'h4, 32'h8, 32'h40, 32'h80};
        wr(MSSP_ADDR_CTRL, {24'h0, 4'h8, m, rt});
        cpol <= m[1];
        cpha <= m[0];
        reply <= rp;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        @(posedge clk);
        edges = 32'h0;
        wr(MSSP_ADDR_DATA, {24'h0, tx});
        rd(MSSP_ADDR_CTRL, d);
        chk("busy", 32'h1, {31'h0, d[4]});
        n = 0;
        while (d[4] !== 1'b0 && n < 2000) begin
            rd(MSSP_ADDR_CTRL, d);
            n++;
        end
        chk("edges", 32'h10, edges);
        chk("span", 32'hF * half[rt], t_last - t_first);
        chk("idle", {31'h0, m[1]}, {31'h0, sck_o});
        chk("tx", {24'h0, tx}, {24'h0, got});
        rd(MSSP_ADDR_DATA, d);
        chk("rx", {24'h0, rp}, d);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic        e;
        rd(MSSP_ADDR_CTRL, d);
        chk("ctrl rst", 32'h0, d);
        rd(MSSP_ADDR_MASK, d);
        chk("mask rst", 32'h0, d);
        wr(MSSP_ADDR_CTRL, 32'h3F);
        rd(MSSP_ADDR_CTRL, d);
        chk("ctrl ro", 32'h0F, d);
        wr(MSSP_ADDR_CTRL, 32'h0);
        apb(1'b0, 12'h0, 32'h0, d, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, d);
    endtask

    task automatic t_disabled;
        logic [31:0] d;
        edges = 32'h0;
        wr(MSSP_ADDR_DATA, 32'h5A);
        repeat (40) @(posedge clk);
        rd(MSSP_ADDR_CTRL, d);
        chk("idle busy", 32'h0, d);
        chk("idle edges", 32'h0, edges);
        chk("pins free", 32'h0, {30'h0, sck_oe, so_oe});
    endtask

    task automatic t_irq;
        logic [31:0] d;
        rd(MSSP_ADDR_STAT, d);
        wr(MSSP_ADDR_MASK, 32'h1 << MSSP_IRQ_BYTE);
        xfer(2'b01, 2'b00, 8'hC3, 8'h81);
        chk("irq", 32'h3, {30'h0, irq, xirq});
        rd(MSSP_ADDR_STAT, d);
        chk("stat", 32'h1, d);
        @(posedge clk);
        chk("irq clr", 32'h0, {30'h0, irq, xirq});
        wr(MSSP_ADDR_MASK, 32'h0);
        xfer(2'b10, 2'b01, 8'h01, 8'hFE);
        chk("masked", 32'h0, {31'h0, irq});
        rd(MSSP_ADDR_STAT, d);
        wr(MSSP_ADDR_CTRL, 32'h0);
        ext_pin <= 1'b1;
        repeat (10) @(posedge clk);
        chk("pin src", 32'h1, {31'h0, xirq});
        ext_pin <= 1'b0;
    endtask

    task automatic conclude;
        if (error_cnt == 32'h0 && comparisons != 32'h0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_disabled();
        xfer(2'b00, 2'b00, 8'hA5, 8'h3C);
        xfer(2'b01, 2'b01, 8'h96, 8'h5A);
        xfer(2'b10, 2'b10, 8'h80, 8'h01);
        xfer(2'b11, 2'b11, 8'h7E, 8'hE7);
        t_irq();
        conclude();
    end
endmodule // testbench
`default_nettype wire

// ---- hw/mssp_pkg.sv ----
package mssp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  MSSP_IDX_DATA    = 8'hFD;
    localparam logic [7:0]  MSSP_IDX_CTRL    = 8'hFE;
    localparam logic [7:0]  MSSP_IDX_STAT    = 8'hFB;
    localparam logic [7:0]  MSSP_IDX_MASK    = 8'hFC;
    localparam logic [11:0] MSSP_ADDR_DATA   = {2'h0, MSSP_IDX_DATA, 2'h0};
    localparam logic [11:0] MSSP_ADDR_CTRL   = {2'h0, MSSP_IDX_CTRL, 2'h0};
    localparam logic [11:0] MSSP_ADDR_STAT   = {2'h0, MSSP_IDX_STAT, 2'h0};
    localparam logic [11:0] MSSP_ADDR_MASK   = {2'h0, MSSP_IDX_MASK, 2'h0};

    // Control register fields
    localparam int          MSSP_CTL_EN      = 7;
    localparam int          MSSP_CTL_BMS     = 6;
    localparam int          MSSP_CTL_BUSY    = 4;
    localparam int          MSSP_CTL_CPOL    = 3;
    localparam int          MSSP_CTL_CPHA    = 2;
    localparam logic [7:0]  MSSP_CTL_WMASK   = 8'hCF;
    localparam logic [7:0]  MSSP_CTL_RESET   = 8'h00;

    // Interrupt status fields
    localparam int          MSSP_IRQ_BYTE    = 0;
    localparam int          MSSP_IRQ_STSP    = 1;
    localparam int          MSSP_IRQ_ARB     = 2;
    localparam int          MSSP_IRQ_EXT     = 3;
    localparam int          MSSP_IRQ_W       = 4;

    // Half shift-clock period in core clocks: full divide 8, 16, 128, 256
    localparam logic [6:0]  MSSP_HALF_R0     = 7'h04;
    localparam logic [6:0]  MSSP_HALF_R1     = 7'h08;
    localparam logic [6:0]  MSSP_HALF_R2     = 7'h40;
    localparam logic [6:0]  MSSP_HALF_R3     = 7'h00;
    localparam logic [3:0]  MSSP_LAST_EDGE   = 4'hF;
    localparam int          MSSP_SYNC_N      = 3;

    typedef enum logic [1:0] {
        MSSP_IDLE = 2'b00,
        MSSP_RUN  = 2'b01,
        MSSP_DONE = 2'b10
    } mssp_state_t;
endpackage

// ---- hw/mssp_rate_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module mssp_rate_gen
    import mssp_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    mssp_rate_if.gen   rif
);
    logic [6:0] cnt_r;
    logic [6:0] half;

    always_comb begin
        unique case (rif.rate)
            2'b00: half = MSSP_HALF_R0;
            2'b01: half = MSSP_HALF_R1;
            2'b10: half = MSSP_HALF_R2;
            2'b11: half = MSSP_HALF_R3;
        endcase
    end

    // Half 0 wraps through 128 counts for the slowest rate
    always_ff @(posedge clk) begin
        if (rst || !rif.run) begin
            cnt_r <= 7'h01;
        end else if (!rif.hold) begin
            cnt_r <= (cnt_r == half) ? 7'h01 : cnt_r + 7'h01;
        end
    end

    assign rif.tick = rif.run && !rif.hold && (cnt_r == half);

    a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
        rif.tick |=> !rif.tick [*3]) else $error("shift clock ticks too close");
endmodule // mssp_rate_gen
`default_nettype wire

// ---- hw/mssp_rate_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mssp_rate_if;
    logic       run;
    logic       hold;
    logic [1:0] rate;
    logic       tick;
    modport ctl (output run, output hold, output rate, input tick);
    modport gen (input run, input hold, input rate, output tick);
endinterface
`default_nettype wire

// ---- hw/mssp_top.sv ----
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Three lines: data out, data in, clock
// - Enabled write shifts byte out MSB first
// - Input sampled same transfer, replaces outgoing byte
// - After eight clocks, byte to read buffer
// - Busy bit 4 high during transfer
// - Master only; clock always generated here
// - Clock polarity and phase programmable
// - Rate field divides core clock 8/16/128/256
// - Bus mode: clock stretching, arbitration loss
// - Interrupts raised on external channel two while enabled; it carries the pin when disabled
// - Source: pin, start/stop, arbitration loss, or byte end
// - Data at index 253, control at 254
module mssp_top
    import mssp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             serial_out_line_o,
    output logic             serial_out_line_oe,
    input  wire logic        serial_in_line_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        sck_i,
    input  wire logic        external_irq_channel_two_pin,
    output logic             external_irq_channel_two,
    output logic             irq
);
    mssp_rate_if rif ();

    mssp_state_t           state_r;
    logic [7:0]            ctrl_r;
    logic [7:0]            shift_r;
    logic [7:0]            rx_buf_r;
    logic [3:0]            edge_r;
    logic                  tgl_r;
    logic                  out_r;
    logic [MSSP_IRQ_W-1:0] stat_r;
    logic [MSSP_IRQ_W-1:0] mask_r;
    logic [MSSP_IRQ_W-1:0] stat_set;
    logic [31:0]           prdata_r;
    logic [2:0]            s1_r;
    logic [2:0]            s2_r;
    logic [2:0]            s3_r;
    logic [2:0]            filt_r;
    logic [2:0]            filt_d_r;

    logic en;
    logic bus_mode_select;
    logic cpha;
    logic sck_lvl;
    logic sin_f;
    logic sin_s;
    logic sck_f;
    logic ext_f;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic start;
    logic sample_edge;
    logic launch_edge;
    logic arb_lost;
    logic stsp;
    logic busy;

    assign en      = ctrl_r[MSSP_CTL_EN];
    assign bus_mode_select     = ctrl_r[MSSP_CTL_BMS];
    assign cpha    = ctrl_r[MSSP_CTL_CPHA];
    assign busy    = (state_r != MSSP_IDLE);
    assign sck_lvl = ctrl_r[MSSP_CTL_CPOL] ^ tgl_r;

    // APB slave: zero wait states, error on unmapped word
    assign acc     = psel && penable;
    assign wr      = acc && pwrite;
    assign rd      = acc && !pwrite;
    assign mapped  = (paddr == MSSP_ADDR_DATA) || (paddr == MSSP_ADDR_CTRL) ||
                     (paddr == MSSP_ADDR_STAT) || (paddr == MSSP_ADDR_MASK);
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = prdata_r;

    // Pin inputs: three flops, a level counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < MSSP_SYNC_N; g++) begin : g_sync
            logic pin;
            if (g == 0) begin : g_sin
                assign pin = serial_in_line_i;
            end else if (g == 1) begin : g_sck
                assign pin = sck_i;
            end else begin : g_ext
                assign pin = external_irq_channel_two_pin;
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_r[g]     <= 1'b1;
                    s2_r[g]     <= 1'b1;
                    s3_r[g]     <= 1'b1;
                    filt_r[g]   <= 1'b1;
                    filt_d_r[g] <= 1'b1;
                end else begin
                    s1_r[g]     <= pin;
                    s2_r[g]     <= s1_r[g];
                    s3_r[g]     <= s2_r[g];
                    filt_d_r[g] <= filt_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        filt_r[g] <= s2_r[g];
                    end
                end
            end
        end
    endgenerate

    assign sin_f = filt_r[0];
    // Sampling takes the agreed level one edge before the filter flop holds it,
    // so a bit launched a half period earlier at the fastest rate is caught
    assign sin_s = (s2_r[0] == s3_r[0]) ? s2_r[0] : filt_r[0];
    assign sck_f = filt_r[1];
    assign ext_f = filt_r[2];

    // Rate divider; in bus mode a released clock held low by a slave stalls it
    assign rif.run  = (state_r == MSSP_RUN);
    assign rif.rate = ctrl_r[1:0];
    assign rif.hold = bus_mode_select && sck_lvl && !sck_f;

    mssp_rate_gen u_rate (
        .clk (clk),
        .rst (rst),
        .rif (rif)
    );

    assign start       = wr && (paddr == MSSP_ADDR_DATA) && en && !busy;
    assign sample_edge = rif.tick && (edge_r[0] == cpha);
    assign launch_edge = rif.tick && (edge_r[0] != cpha) && (edge_r != MSSP_LAST_EDGE);
    assign arb_lost    = bus_mode_select && sample_edge && out_r && !sin_s;
    // Start or stop: data line moves while the clock line stands high
    assign stsp        = en && bus_mode_select && sck_f && filt_d_r[1] && (sin_f != filt_d_r[0]);

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= MSSP_CTL_RESET;
            mask_r <= '0;
        end else if (wr && paddr == MSSP_ADDR_CTRL) begin
            ctrl_r <= pwdata[7:0] & MSSP_CTL_WMASK;
        end else if (wr && paddr == MSSP_ADDR_MASK) begin
            mask_r <= pwdata[MSSP_IRQ_W-1:0];
        end
    end

    // Transfer engine: sixteen clock edges carry eight bits
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= MSSP_IDLE;
            edge_r  <= '0;
            tgl_r   <= 1'b0;
        end else if (!en) begin
            state_r <= MSSP_IDLE;
            edge_r  <= '0;
            tgl_r   <= 1'b0;
        end else begin
            unique case (state_r)
                MSSP_IDLE: begin
                    tgl_r  <= 1'b0;
                    edge_r <= '0;
                    if (start) begin
                        state_r <= MSSP_RUN;
                    end
                end
                MSSP_RUN: begin
                    if (arb_lost) begin
                        state_r <= MSSP_IDLE;
                        tgl_r   <= 1'b0;
                    end else if (rif.tick) begin
                        tgl_r  <= ~tgl_r;
                        edge_r <= edge_r + 4'h1;
                        if (edge_r == MSSP_LAST_EDGE) begin
                            state_r <= MSSP_DONE;
                        end
                    end
                end
                MSSP_DONE: begin
                    state_r <= MSSP_IDLE;
                end
                default: begin
                    state_r <= MSSP_IDLE;
                end
            endcase
        end
    end

    // Shared shift register: input bits enter as output bits leave
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_r <= '0;
            out_r   <= 1'b1;
        end else if (start) begin
            shift_r <= pwdata[7:0];
            out_r   <= pwdata[7];
        end else if (state_r == MSSP_RUN) begin
            if (sample_edge) begin
                shift_r <= {shift_r[6:0], sin_s};
            end
            if (launch_edge) begin
                out_r <= shift_r[7];
            end
        end
    end

    // Receive buffer loaded in parallel once the byte is complete
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_buf_r <= '0;
        end else if (state_r == MSSP_DONE) begin
            rx_buf_r <= shift_r;
        end
    end

    // Interrupt source follows enable and bus mode
    always_comb begin
        stat_set                = '0;
        stat_set[MSSP_IRQ_BYTE] = en && !bus_mode_select && (state_r == MSSP_DONE);
        stat_set[MSSP_IRQ_STSP] = stsp;
        stat_set[MSSP_IRQ_ARB]  = arb_lost;
        stat_set[MSSP_IRQ_EXT]  = !en && ext_f && !filt_d_r[2];
    end

    // Read clears status, but an event in the same cycle survives
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_r <= '0;
        end else if (rd && paddr == MSSP_ADDR_STAT) begin
            stat_r <= stat_set;
        end else begin
            stat_r <= stat_r | stat_set;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= '0;
            if (paddr == MSSP_ADDR_DATA) begin
                prdata_r[7:0] <= rx_buf_r;
            end else if (paddr == MSSP_ADDR_CTRL) begin
                prdata_r[7:0]         <= ctrl_r;
                prdata_r[MSSP_CTL_BUSY] <= busy;
            end else if (paddr == MSSP_ADDR_STAT) begin
                prdata_r[MSSP_IRQ_W-1:0] <= stat_r;
            end else if (paddr == MSSP_ADDR_MASK) begin
                prdata_r[MSSP_IRQ_W-1:0] <= mask_r;
            end
        end
    end

    assign irq = |(stat_r & mask_r);
    // Channel two carries the pin when disabled, the port's events otherwise
    assign external_irq_channel_two = en ? irq : ext_f;

    // Pins: open drain in bus mode, released to GPIO while disabled
    assign serial_out_line_o  = out_r;
    assign serial_out_line_oe = en && (!bus_mode_select || !out_r);
    assign sck_o              = sck_lvl;
    assign sck_oe             = en && (!bus_mode_select || !sck_lvl);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_idle_clock: assert property (!busy |-> (sck_lvl == ctrl_r[MSSP_CTL_CPOL]))
        else $error("clock left its idle level");
    a_disabled_quiet: assert property (!en |-> !serial_out_line_oe && !sck_oe ##1 !busy)
        else $error("port active while disabled");
    a_msb_first: assert property (start |=> busy && (out_r == $past(pwdata[7])))
        else $error("first bit out is not the MSB");
    a_buffer_load: assert property ((state_r == MSSP_DONE) |=> (rx_buf_r == $past(shift_r)))
        else $error("received byte not buffered");
    a_sixteen_edges: assert property ($rose(state_r == MSSP_DONE) |->
        ($past(edge_r) == MSSP_LAST_EDGE)) else $error("byte ended early");
    a_busy_read: assert property ((psel && !penable && !pwrite && paddr == MSSP_ADDR_CTRL)
        |=> (prdata_r[MSSP_CTL_BUSY] == $past(busy))) else $error("busy bit wrong");
    a_arb_abort: assert property (arb_lost |=> !busy ##1 (stat_r[MSSP_IRQ_ARB] || $past(rd)))
        else $error("arbitration loss not handled");
    a_stretch_hold: assert property (rif.hold && busy |=> $stable(tgl_r))
        else $error("clock advanced while stretched");
    a_byte_irq: assert property (en && !bus_mode_select && (state_r == MSSP_DONE) &&
        mask_r[MSSP_IRQ_BYTE] && !rd |=> irq && external_irq_channel_two)
        else $error("byte end gave no interrupt");
endmodule // mssp_top
`default_nettype wire
